// >>> core/event_capture_consts.svh
`ifndef EVENT_CAPTURE_CONSTS_SVH
`define EVENT_CAPTURE_CONSTS_SVH

// Register addresses
`define ADDR_SYS_CAPTURE_ENABLE 7'h04
`define ADDR_SUP_CAPTURE_ENABLE 7'h1c
`define ADDR_TRX_CAPTURE_ENABLE 7'h23
`define ADDR_GLOBAL_SUMMARY     7'h60
`define ADDR_SYSTEM_FLAGS       7'h61
`define ADDR_SUPPLY_FLAGS       7'h62
`define ADDR_TRX_FLAGS          7'h63

// System flag and enable fields
`define BIT_POWER_ON            4
`define BIT_OVERTEMP            2
`define BIT_SERIAL_FAIL         1
`define BIT_WATCHDOG_FAIL       0
// Supply fields
`define BIT_UNDERVOLTAGE        0
// Transceiver fields
`define BIT_BUS_SILENCE         4
`define BIT_CAN_FAILURE         1
`define BIT_BUS_WAKEUP          0
// Summary fields
`define BIT_TRX_PENDING         2
`define BIT_SUP_PENDING         1
`define BIT_SYS_PENDING         0

// Writable masks
`define MASK_SYSTEM             8'h17
`define MASK_SUPPLY             8'h01
`define MASK_TRX                8'h13
`define MASK_SYS_ENABLE         8'h06

// Reset values
`define RESET_SYS_ENABLE        8'h00
`define RESET_SUP_ENABLE        8'h00
`define RESET_TRX_ENABLE        8'h00

// Event delay time and its cycle count at 125 MHz
`define EVENT_DELAY_US          10
`define CLK_MHZ                 125
`define EVENT_DELAY_CYCLES      (`EVENT_DELAY_US * `CLK_MHZ)

`endif

// >>> core/event_capture_pkg.sv
`default_nettype none
package event_capture_pkg;
   typedef enum logic [1:0] {
      DELAY_IDLE = 2'b01,
      DELAY_RUN  = 2'b10
   } delay_state_e;
endpackage
`default_nettype wire

// >>> core/w1c_flag_group.sv
`default_nettype none
// One group of sticky event flags with capture gating and write-one clear
module w1c_flag_group #(
   parameter logic [7:0] MASK = 8'hff
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   input  wire logic [7:0] event_in,
   input  wire logic [7:0] capture_en,
   input  wire logic       clear_wr,
   input  wire logic [7:0] clear_data,
   output logic      [7:0] flags,
   output logic            any_cleared
);
   typedef struct packed {
      logic [7:0] flags;
   } state_s;

   state_s     s_q;
   state_s     s_d;
   logic [7:0] set_v;
   logic [7:0] clr_v;

   always_comb begin
      s_d   = s_q;
      set_v = event_in & capture_en & MASK;
      clr_v = clear_wr ? (clear_data & MASK) : 8'h00;
      // A new event wins over a simultaneous clear
      s_d.flags = ((s_q.flags & ~clr_v) | set_v) & MASK;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign flags       = s_q.flags;
   assign any_cleared = |(clr_v & s_q.flags);
endmodule // w1c_flag_group
`default_nettype wire

// >>> core/sbc_event_capture_notify.sv
`include "event_capture_consts.svh"
`default_nettype none
module sbc_event_capture_notify #(
   parameter int unsigned EVENT_DELAY_CYCLES = `EVENT_DELAY_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   // Register port from the serial interface
   input  wire logic       reg_wr,
   input  wire logic [6:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Event sources
   input  wire logic       off_state_exit,
   input  wire logic       overtemp_warning_event,
   input  wire logic       serial_clock_count_error,
   input  wire logic       illegal_code_write,
   input  wire logic       locked_register_write,
   input  wire logic       watchdog_overflow,
   input  wire logic       watchdog_early_trigger,
   input  wire logic       watchdog_window_mode,
   input  wire logic       watchdog_timeout_mode,
   input  wire logic       regulated_output_active,
   input  wire logic       regulated_output_below_90,
   input  wire logic       bus_silence_timeout,
   input  wire logic       bus_was_active,
   input  wire logic       trx_off_by_undervoltage,
   input  wire logic       trx_off_by_clamped_txd,
   input  wire logic       bus_wakeup_event,
   input  wire logic       transceiver_offline,
   // Operating state of the chip
   input  wire logic       in_reset_state,
   input  wire logic       in_overtemp_state,
   input  wire logic       in_off_state,
   // Outputs
   output logic            watchdog_system_reset,
   output logic            reset_output_pin,
   output logic            rxd_out
);
   typedef struct packed {
      event_capture_pkg::delay_state_e state;
      logic [31:0]                     count;
      logic [7:0]                      sys_en;
      logic [7:0]                      sup_en;
      logic [7:0]                      trx_en;
      logic                            reset_output_pin_out;
      logic                            wd_reset;
      logic                            rxd;
      logic [7:0]                      rdata;
   } state_s;

   state_s     s_q;
   state_s     s_d;
   logic [7:0] sys_flags;
   logic [7:0] sup_flags;
   logic [7:0] trx_flags;
   logic [7:0] sys_evt;
   logic [7:0] sup_evt;
   logic [7:0] trx_evt;
   logic [7:0] sys_cap;
   logic       sys_clr_any;
   logic       sup_clr_any;
   logic       trx_clr_any;
   logic       any_pending;
   logic [7:0] summary;
   logic       reset_output_pin_d;
   logic       reset_output_pin_fall;
   logic       timeout_overflow;
   logic       sys_clr_wr;
   logic       sup_clr_wr;
   logic       trx_clr_wr;
   logic       any_clr;
   logic       notify_low;

   assign timeout_overflow = watchdog_overflow & watchdog_timeout_mode;

   // Write-one-clear strobes, one per flag group
   assign sys_clr_wr = reg_wr && reg_addr == `ADDR_SYSTEM_FLAGS;
   assign sup_clr_wr = reg_wr && reg_addr == `ADDR_SUPPLY_FLAGS;
   assign trx_clr_wr = reg_wr && reg_addr == `ADDR_TRX_FLAGS;

   always_comb begin
      sys_evt = 8'h00;
      sys_evt[`BIT_POWER_ON]      = off_state_exit;
      sys_evt[`BIT_OVERTEMP]      = overtemp_warning_event;
      sys_evt[`BIT_SERIAL_FAIL]   = serial_clock_count_error | illegal_code_write
                                    | locked_register_write;
      sys_evt[`BIT_WATCHDOG_FAIL] = (watchdog_overflow
                                     & (watchdog_window_mode | watchdog_timeout_mode))
                                    | (watchdog_early_trigger & watchdog_window_mode);
      // Power-on and watchdog bypass the enable register
      sys_cap = s_q.sys_en;
      sys_cap[`BIT_POWER_ON]      = 1'b1;
      sys_cap[`BIT_WATCHDOG_FAIL] = 1'b1;
      sup_evt = 8'h00;
      sup_evt[`BIT_UNDERVOLTAGE] = regulated_output_active & regulated_output_below_90;
      trx_evt = 8'h00;
      trx_evt[`BIT_BUS_SILENCE] = bus_silence_timeout & bus_was_active;
      trx_evt[`BIT_CAN_FAILURE] = trx_off_by_undervoltage | trx_off_by_clamped_txd;
      trx_evt[`BIT_BUS_WAKEUP]  = bus_wakeup_event;
   end

   w1c_flag_group #(.MASK(`MASK_SYSTEM)) u_sys (
      .clk        (clk),
      .reset_n    (reset_n),
      .clk_en     (clk_en),
      .event_in   (sys_evt),
      .capture_en (sys_cap),
      .clear_wr   (sys_clr_wr),
      .clear_data (reg_wdata),
      .flags      (sys_flags),
      .any_cleared(sys_clr_any)
   );

   w1c_flag_group #(.MASK(`MASK_SUPPLY)) u_sup (
      .clk        (clk),
      .reset_n    (reset_n),
      .clk_en     (clk_en),
      .event_in   (sup_evt),
      .capture_en (s_q.sup_en),
      .clear_wr   (sup_clr_wr),
      .clear_data (reg_wdata),
      .flags      (sup_flags),
      .any_cleared(sup_clr_any)
   );

   w1c_flag_group #(.MASK(`MASK_TRX)) u_trx (
      .clk        (clk),
      .reset_n    (reset_n),
      .clk_en     (clk_en),
      .event_in   (trx_evt),
      .capture_en (s_q.trx_en),
      .clear_wr   (trx_clr_wr),
      .clear_data (reg_wdata),
      .flags      (trx_flags),
      .any_cleared(trx_clr_any)
   );

   always_comb begin
      summary = 8'h00;
      summary[`BIT_TRX_PENDING] = |trx_flags;
      summary[`BIT_SUP_PENDING] = |sup_flags;
      summary[`BIT_SYS_PENDING] = |sys_flags;
   end
   assign any_pending = |summary;
   // Only a clear of a flag that was set restarts the hold-off
   assign any_clr     = sys_clr_any | sup_clr_any | trx_clr_any;
   // Pin is pulled low only while offline with the regulator up
   assign notify_low  = any_pending & transceiver_offline & regulated_output_active;

   always_comb begin
      s_d = s_q;
      reset_output_pin_d    = ~(in_reset_state | in_overtemp_state | in_off_state);
      s_d.reset_output_pin_out = reset_output_pin_d;
      reset_output_pin_fall = s_q.reset_output_pin_out & ~reset_output_pin_d;

      // Enable registers
      if (reg_wr) begin
         unique case (reg_addr)
            `ADDR_SYS_CAPTURE_ENABLE: s_d.sys_en = reg_wdata & `MASK_SYS_ENABLE;
            `ADDR_SUP_CAPTURE_ENABLE: s_d.sup_en = reg_wdata & `MASK_SUPPLY;
            `ADDR_TRX_CAPTURE_ENABLE: s_d.trx_en = reg_wdata & `MASK_TRX;
            default: ;
         endcase
      end

      // Reads are answered in any timer state
      unique case (reg_addr)
         `ADDR_SYS_CAPTURE_ENABLE: s_d.rdata = s_q.sys_en;
         `ADDR_SUP_CAPTURE_ENABLE: s_d.rdata = s_q.sup_en;
         `ADDR_TRX_CAPTURE_ENABLE: s_d.rdata = s_q.trx_en;
         `ADDR_GLOBAL_SUMMARY:     s_d.rdata = summary;
         `ADDR_SYSTEM_FLAGS:       s_d.rdata = sys_flags;
         `ADDR_SUPPLY_FLAGS:       s_d.rdata = sup_flags;
         `ADDR_TRX_FLAGS:          s_d.rdata = trx_flags;
         default:                  s_d.rdata = 8'h00;
      endcase

      // Watchdog reset request
      s_d.wd_reset = (watchdog_window_mode
                      & (watchdog_overflow | watchdog_early_trigger))
                     | (timeout_overflow & sys_flags[`BIT_WATCHDOG_FAIL]);

      // Event delay timer and receive pin
      unique case (s_q.state)
         event_capture_pkg::DELAY_IDLE: begin
            if (any_clr) begin
               s_d.state = event_capture_pkg::DELAY_RUN;
               s_d.count = 32'h0;
               s_d.rxd   = 1'b1;
            end else begin
               s_d.rxd = ~notify_low;
            end
         end
         event_capture_pkg::DELAY_RUN: begin
            s_d.rxd = 1'b1;
            if (any_clr) begin
               s_d.count = 32'h0;
            end else if (s_q.count >= EVENT_DELAY_CYCLES - 1) begin
               s_d.state = event_capture_pkg::DELAY_IDLE;
               // Pin goes low only if something is still pending
               s_d.rxd = ~notify_low;
            end else begin
               s_d.count = s_q.count + 32'h1;
            end
         end
         default: begin
            s_d.state = event_capture_pkg::DELAY_IDLE;
            s_d.rxd   = 1'b1;
         end
      endcase

      if (reset_output_pin_fall) begin
         s_d.state = event_capture_pkg::DELAY_IDLE;
         s_d.count = 32'h0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q.state    <= event_capture_pkg::DELAY_IDLE;
         s_q.count    <= 32'h0;
         s_q.sys_en   <= `RESET_SYS_ENABLE;
         s_q.sup_en   <= `RESET_SUP_ENABLE;
         s_q.trx_en   <= `RESET_TRX_ENABLE;
         s_q.reset_output_pin_out <= 1'b0;
         s_q.wd_reset <= 1'b0;
         s_q.rxd      <= 1'b1;
         s_q.rdata    <= 8'h00;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign reg_rdata             = s_q.rdata;
   assign reset_output_pin      = s_q.reset_output_pin_out;
   assign watchdog_system_reset = s_q.wd_reset;
   assign rxd_out               = s_q.rxd;
endmodule // sbc_event_capture_notify
`default_nettype wire

// >>> verif/event_capture_chk.sv
`default_nettype none
module event_capture_chk (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       clk_en,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic       off_state_exit,
   input wire logic       watchdog_overflow,
   input wire logic       watchdog_early_trigger,
   input wire logic       watchdog_window_mode,
   input wire logic       regulated_output_active,
   input wire logic       transceiver_offline,
   input wire logic       in_reset_state,
   input wire logic       in_overtemp_state,
   input wire logic       in_off_state,
   input wire logic       watchdog_system_reset,
   input wire logic       reset_output_pin,
   input wire logic       rxd_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic bad_state;
   assign bad_state = in_reset_state | in_overtemp_state | in_off_state;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_rst_out; clk_en && bad_state |=> !reset_output_pin; endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset pin not low");
   property p_po;
      clk_en && off_state_exit && reg_addr == 7'h61 ##1 clk_en && reg_addr == 7'h61
      |=> reg_rdata[4];
   endproperty
   a_po: assert property (p_po) else $error("power-on flag missing");
   property p_sum; clk_en && reg_addr == 7'h60 |=> reg_rdata[7:3] == 5'h00; endproperty
   a_sum: assert property (p_sum) else $error("summary upper bits set");
   property p_sys; clk_en && reg_addr == 7'h61 |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[3];
   endproperty
   a_sys: assert property (p_sys) else $error("system reserved bits set");
   property p_wd_win;
      clk_en && watchdog_window_mode && (watchdog_overflow || watchdog_early_trigger)
      |=> watchdog_system_reset;
   endproperty
   a_wd_win: assert property (p_wd_win) else $error("window reset missing");
   property p_wd_src;
      watchdog_system_reset |-> $past(watchdog_overflow || watchdog_early_trigger);
   endproperty
   a_wd_src: assert property (p_wd_src) else $error("reset without cause");
   property p_rxd_off;
      clk_en && !(transceiver_offline && regulated_output_active) |=> rxd_out;
   endproperty
   a_rxd_off: assert property (p_rxd_off) else $error("rxd low while online");
   property p_rxd_hold;
      $rose(rxd_out) && $past(transceiver_offline && regulated_output_active) && !bad_state
      && reset_output_pin |-> ##1 rxd_out;
   endproperty
   a_rxd_hold: assert property (p_rxd_hold) else $error("rxd hold-off cut");
endmodule // event_capture_chk
bind sbc_event_capture_notify event_capture_chk i_chk (.*);
`default_nettype wire

// >>> verif/mcu_poll_model.sv
`default_nettype none
module mcu_poll_model (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output var  logic       reg_wr,
   output var  logic [6:0] reg_addr,
   output var  logic [7:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      #1 d = reg_rdata;
   endtask
   // Clears only what was seen, so events landing meanwhile survive
   task automatic service(input logic [6:0] a, output logic [7:0] d);
      rd(a, d);
      wr(a, d);
   endtask
endmodule // mcu_poll_model
`default_nettype wire

// >>> verif/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [19:0] ev = 20'h10200;
   logic        reg_wr;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        wsr;
   logic        rst_pin;
   logic        rxd;
   logic        wsr_seen;
   logic [7:0]  v;
   int          n_mismatch = 0;
   int          checks = 0;
   always #4 clk = ~clk;
   mcu_poll_model i_mcu (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   sbc_event_capture_notify #(.EVENT_DELAY_CYCLES(8)) i_dut (
      .clk(clk), .reset_n(reset_n), .clk_en(1'b1),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .off_state_exit(ev[0]), .overtemp_warning_event(ev[1]),
      .serial_clock_count_error(ev[2]), .illegal_code_write(ev[3]),
      .locked_register_write(ev[4]), .watchdog_overflow(ev[5]),
      .watchdog_early_trigger(ev[6]), .watchdog_window_mode(ev[7]),
      .watchdog_timeout_mode(ev[8]), .regulated_output_active(ev[9]),
      .regulated_output_below_90(ev[10]), .bus_silence_timeout(ev[11]),
      .bus_was_active(ev[12]), .trx_off_by_undervoltage(ev[13]),
      .trx_off_by_clamped_txd(ev[14]), .bus_wakeup_event(ev[15]),
      .transceiver_offline(ev[16]), .in_reset_state(ev[17]),
      .in_overtemp_state(ev[18]), .in_off_state(ev[19]),
      .watchdog_system_reset(wsr), .reset_output_pin(rst_pin), .rxd_out(rxd));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
      #1 wsr_seen = wsr;
   endtask
   task automatic lvl(input int i, input logic b);
      @(posedge clk);
      ev[i] <= b;
   endtask
   task automatic s_regs;
      logic [6:0] a [5] = '{7'h04, 7'h1c, 7'h23, 7'h60, 7'h10};
      logic [7:0] e [3] = '{8'h01, 8'h13, 8'h00};
      foreach (a[k]) begin
         i_mcu.rd(a[k], v);
         chk(v, 8'h00);
      end
      for (int k = 1; k < 4; k++) begin
         i_mcu.wr(a[k], 8'hff);
         i_mcu.rd(a[k], v);
         chk(v, e[k-1]);
      end
   endtask
   task automatic s_sys;
      i_mcu.rd(7'h61, v);
      pulse(1);
      pulse(2);
      pulse(0);
      i_mcu.rd(7'h61, v);
      chk(v, 8'h10);
      lvl(8, 1'b1);
      pulse(5);
      chk({7'h00, wsr_seen}, 8'h00);
      pulse(5);
      chk({7'h00, wsr_seen}, 8'h01);
      i_mcu.service(7'h61, v);
      chk(v, 8'h11);
      lvl(8, 1'b0);
      lvl(7, 1'b1);
      pulse(6);
      chk({7'h00, wsr_seen}, 8'h01);
      lvl(7, 1'b0);
      i_mcu.wr(7'h04, 8'hff);
      for (int i = 1; i < 5; i++) begin
         pulse(i);
         i_mcu.service(7'h61, v);
         chk(v, i == 1 ? 8'h05 : 8'h02);
      end
   endtask
   task automatic s_trx;
      pulse(11);
      lvl(12, 1'b1);
      pulse(11);
      lvl(12, 1'b0);
      pulse(13);
      i_mcu.service(7'h63, v);
      chk(v, 8'h12);
      pulse(14);
      pulse(15);
      pulse(10);
      i_mcu.rd(7'h60, v);
      chk(v, 8'h06);
      i_mcu.rd(7'h62, v);
      chk(v, 8'h01);
      i_mcu.service(7'h63, v);
      chk(v, 8'h03);
   endtask
   task automatic s_rxd;
      repeat (12) @(posedge clk);
      #1 chk({7'h00, rxd}, 8'h00);
      pulse(15);
      i_mcu.wr(7'h63, 8'h01);
      #1 chk({7'h00, rxd}, 8'h01);
      repeat (5) @(posedge clk);
      #1 chk({7'h00, rxd}, 8'h01);
      repeat (6) @(posedge clk);
      #1 chk({7'h00, rxd}, 8'h00);
      i_mcu.wr(7'h62, 8'h01);
      repeat (12) @(posedge clk);
      #1 chk({7'h00, rxd}, 8'h01);
      pulse(15);
      fork
         i_mcu.wr(7'h63, 8'h01);
         pulse(15);
      join
      i_mcu.rd(7'h63, v);
      chk(v, 8'h01);
      lvl(16, 1'b0);
      repeat (12) @(posedge clk);
      #1 chk({7'h00, rxd}, 8'h01);
      lvl(16, 1'b1);
      pulse(10);
      i_mcu.wr(7'h62, 8'h01);
      lvl(17, 1'b1);
      repeat (4) @(posedge clk);
      #1 chk({6'h00, rst_pin, rxd}, 8'h00);
      lvl(17, 1'b0);
   endtask
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #50us;
      n_mismatch++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge clk);
      #1 chk({6'h00, rst_pin, rxd}, 8'h01);
      @(posedge clk);
      reset_n <= 1'b1;
      s_regs();
      s_sys();
      s_trx();
      s_rxd();
      end_sim();
   end
endmodule // tb
`default_nettype wire
